// file: dual_tap_pkg.sv
// constants and types shared by the dual test access port
package dual_tap_pkg;

    // ****************************************************
    // tap controller states and register widths
    // ****************************************************
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_e;

    localparam int IR_W    = 4;
    localparam int DATA_W  = 32;
    // instruction codes, values arbitrary
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] IR_DATA   = 4'h2;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    // capture pattern for the instruction register low bits
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    // identity words, values arbitrary
    localparam logic [DATA_W-1:0] ID_SCAN  = 32'h0000_1001;
    localparam logic [DATA_W-1:0] ID_DEBUG = 32'h0000_2001;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

endpackage

// file: dual_tap_props.sv
// concurrent checks on the pins of the dual test access port
`timescale 1ns/1ns
`default_nettype none
module dual_tap_props (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_test_resetn,
    input wire logic        i_test_clk,
    input wire logic        i_scan_mode_select,
    input wire logic        i_debug_mode_select,
    input wire logic        o_test_data_out,
    input wire logic        o_test_data_out_en,
    input wire logic [31:0] o_scan_data,
    input wire logic [31:0] o_debug_data,
    input wire logic        o_scan_in_reset,
    input wire logic        o_debug_in_reset
);
    // ****
    // pin relations on the system clock
    // ****
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_reset_quiet: assert property (!i_test_resetn |->
        !o_test_data_out_en && o_scan_in_reset && o_debug_in_reset)
        else $error("test reset not obeyed");
    a_idle_hiz: assert property (o_scan_in_reset && o_debug_in_reset
        |-> !o_test_data_out_en) else $error("pin driven in reset");
    // select must be steady a few cycles, it crosses two flops
    a_scan_held: assert property (i_scan_mode_select[*4] ##0
        o_scan_in_reset |=> o_scan_in_reset) else $error("scan left reset");
    a_debug_held: assert property (i_debug_mode_select[*4] ##0
        o_debug_in_reset |=> o_debug_in_reset) else $error("debug left reset");
    a_out_on_fall: assert property (i_test_resetn &&
        (!$stable(o_test_data_out_en) || o_test_data_out_en &&
        !$stable(o_test_data_out)) |-> !i_test_clk && !$past(i_test_clk, 2))
        else $error("output moved off a fall");
    a_data_on_edge: assert property (i_test_resetn &&
        !$stable({o_scan_data, o_debug_data}) |->
        i_test_clk != $past(i_test_clk, 6)) else $error("data moved idle");
    c_shift_out: cover property ($rose(o_test_data_out_en));
    c_scan_run: cover property ($fell(o_scan_in_reset));
    c_debug_run: cover property ($fell(o_debug_in_reset));
endmodule
bind dual_tap_test_port dual_tap_props i_dual_tap_props (.i_clk, .i_resetn,
    .i_test_resetn, .i_test_clk, .i_scan_mode_select, .i_debug_mode_select,
    .o_test_data_out, .o_test_data_out_en, .o_scan_data, .o_debug_data,
    .o_scan_in_reset, .o_debug_in_reset);
`default_nettype wire

// file: dual_tap_test_port.sv
// two tap controllers sharing test clock, data in, data out and reset
//
// Summary of operation
// - test reset low asynchronously resets scan logic and both controllers
// - serial data output tri-stated unless a controller is shifting
// - separate mode selects drive the scan and debug controller
// - all shifting timed by the test clock, asynchronous to system
// - single serial input feeds whichever controller is shifting
`timescale 1ns/1ns
`default_nettype none

module dual_tap_test_port
    import dual_tap_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_test_resetn,
    input  wire logic              i_test_clk,
    input  wire logic              i_scan_mode_select,
    input  wire logic              i_debug_mode_select,
    input  wire logic              i_test_data_in,
    output logic                   o_test_data_out,
    output logic                   o_test_data_out_en,
    output logic [DATA_W-1:0]      o_scan_data,
    output logic [DATA_W-1:0]      o_debug_data,
    output logic                   o_scan_in_reset,
    output logic                   o_debug_in_reset
);

    // ****************************************************
    // input synchronisers
    // ****************************************************
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic       tck_prev_r;
    logic       trst_meta_r;
    logic       trst_sync_r;

    // two flops on every pin; test reset clears them at once
    // asynchronous test reset
    always_ff @(posedge i_clk or negedge i_resetn or negedge i_test_resetn)
    begin
        if (!i_resetn || !i_test_resetn) begin
            meta_r      <= 4'h0;
            sync_r      <= 4'h0;
            tck_prev_r  <= 1'b0;
            trst_meta_r <= 1'b0;
            trst_sync_r <= 1'b0;
        end else begin
            meta_r      <= {i_test_clk, i_scan_mode_select,
                            i_debug_mode_select, i_test_data_in};
            sync_r      <= meta_r;
            tck_prev_r  <= sync_r[3];
            trst_meta_r <= 1'b1;
            trst_sync_r <= trst_meta_r;
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic scan_tms;
    logic debug_tms;
    logic tdi;

    // edges of the test clock found on the system clock
    assign tck_rise  = sync_r[3] & ~tck_prev_r & trst_sync_r;
    assign tck_fall  = ~sync_r[3] & tck_prev_r & trst_sync_r;
    assign scan_tms  = sync_r[2];
    assign debug_tms = sync_r[1];
    assign tdi       = sync_r[0];

    // ****************************************************
    // the two controllers
    // ****************************************************
    logic scan_shift;
    logic scan_tdo;
    logic debug_shift;
    logic debug_tdo;

    // scan controller on its own mode select
    tap_ctrl #(.ID_WORD(ID_SCAN)) u_scan (
        .i_clk         (i_clk),
        .i_resetn      (i_resetn),
        .i_test_resetn (i_test_resetn),
        .i_rise        (tck_rise),
        .i_fall        (tck_fall),
        .i_tms         (scan_tms),
        .i_tdi         (tdi),
        .o_shifting    (scan_shift),
        .o_tdo         (scan_tdo),
        .o_data        (o_scan_data),
        .o_in_reset    (o_scan_in_reset)
    );

    // debug controller on the other mode select
    tap_ctrl #(.ID_WORD(ID_DEBUG)) u_debug (
        .i_clk         (i_clk),
        .i_resetn      (i_resetn),
        .i_test_resetn (i_test_resetn),
        .i_rise        (tck_rise),
        .i_fall        (tck_fall),
        .i_tms         (debug_tms),
        .i_tdi         (tdi),
        .o_shifting    (debug_shift),
        .o_tdo         (debug_tdo),
        .o_data        (o_debug_data),
        .o_in_reset    (o_debug_in_reset)
    );

    // ****************************************************
    // shared serial output
    // ****************************************************
    logic pin_data_r, pin_data_nxt;
    logic pin_en_r, pin_en_nxt;

    // drive only while shifting; scan wins if both misused
    always_comb begin
        pin_data_nxt = scan_shift ? scan_tdo : debug_tdo;
        pin_en_nxt   = scan_shift | debug_shift;
    end

    // retimed so the pin never shows the mux settling between flops
    // pin released at once on test reset
    always_ff @(posedge i_clk or negedge i_resetn or negedge i_test_resetn)
    begin
        if (!i_resetn || !i_test_resetn) begin
            pin_data_r <= 1'b0;
            pin_en_r   <= 1'b0;
        end else begin
            pin_data_r <= pin_data_nxt;
            pin_en_r   <= pin_en_nxt;
        end
    end

    assign o_test_data_out    = pin_data_r;
    assign o_test_data_out_en = pin_en_r;

endmodule

// one standard tap state machine with ir, bypass, id and data registers
module tap_ctrl
    import dual_tap_pkg::*;
#(
    parameter logic [DATA_W-1:0] ID_WORD = 32'h0000_0001
)(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_test_resetn,
    input  wire logic              i_rise,
    input  wire logic              i_fall,
    input  wire logic              i_tms,
    input  wire logic              i_tdi,
    output logic                   o_shifting,
    output logic                   o_tdo,
    output logic [DATA_W-1:0]      o_data,
    output logic                   o_in_reset
);

    tap_state_e         state_r, state_nxt;
    logic [IR_W-1:0]    ir_sh_r, ir_sh_nxt;
    logic [IR_W-1:0]    ir_r, ir_nxt;
    logic [DATA_W-1:0]  dr_sh_r, dr_sh_nxt;
    logic [DATA_W-1:0]  data_r, data_nxt;
    logic               tdo_r, tdo_nxt;
    logic               en_r, en_nxt;

    // ****************************************************
    // next state, shift and update
    // ****************************************************
    // state and shifts advance on the rising test clock
    always_comb begin
        state_nxt = state_r;
        ir_sh_nxt = ir_sh_r;
        ir_nxt    = ir_r;
        dr_sh_nxt = dr_sh_r;
        data_nxt  = data_r;
        tdo_nxt   = tdo_r;
        en_nxt    = en_r;
        if (i_rise) begin
            case (state_r)
                ST_RESET:    state_nxt = i_tms ? ST_RESET  : ST_IDLE;
                ST_IDLE:     state_nxt = i_tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR:   state_nxt = i_tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR:   state_nxt = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: state_nxt = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: state_nxt = i_tms ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: state_nxt = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: state_nxt = i_tms ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR:   state_nxt = i_tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR:   state_nxt = i_tms ? ST_RESET  : ST_CAP_IR;
                ST_CAP_IR:   state_nxt = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: state_nxt = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: state_nxt = i_tms ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: state_nxt = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: state_nxt = i_tms ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR:   state_nxt = i_tms ? ST_SEL_DR : ST_IDLE;
                default:     state_nxt = ST_RESET;
            endcase
            case (state_r)
                ST_RESET:  ir_nxt    = IR_IDCODE;
                ST_CAP_IR: ir_sh_nxt = IR_CAPTURE;
                ST_UPD_IR: ir_nxt    = ir_sh_r;
                ST_UPD_DR: if (ir_r == IR_DATA) data_nxt = dr_sh_r;
                ST_CAP_DR: begin
                    if (ir_r == IR_IDCODE)
                        dr_sh_nxt = ID_WORD;
                    else if (ir_r == IR_DATA)
                        dr_sh_nxt = data_r;
                    else
                        dr_sh_nxt = DATA_RST;
                end
                // shared serial input into the selected register
                ST_SHIFT_IR: ir_sh_nxt = {i_tdi, ir_sh_r[IR_W-1:1]};
                ST_SHIFT_DR: begin
                    if (ir_r == IR_IDCODE || ir_r == IR_DATA)
                        dr_sh_nxt = {i_tdi, dr_sh_r[DATA_W-1:1]};
                    else
                        dr_sh_nxt[0] = i_tdi; // one-bit bypass
                end
                default: ;
            endcase
        end
        // output and its enable change on the falling test clock
        if (i_fall) begin
            en_nxt  = (state_r == ST_SHIFT_DR) || (state_r == ST_SHIFT_IR);
            tdo_nxt = (state_r == ST_SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
        end
    end

    // test reset forces reset state with no clock edge
    always_ff @(posedge i_clk or negedge i_resetn or negedge i_test_resetn)
    begin
        if (!i_resetn || !i_test_resetn) begin
            state_r <= ST_RESET;
            ir_sh_r <= IR_CAPTURE;
            ir_r    <= IR_IDCODE;
            dr_sh_r <= DATA_RST;
            data_r  <= DATA_RST;
            tdo_r   <= 1'b0;
            en_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r    <= ir_nxt;
            dr_sh_r <= dr_sh_nxt;
            data_r  <= data_nxt;
            tdo_r   <= tdo_nxt;
            en_r    <= en_nxt;
        end
    end

    // shifting flag gates the shared output
    assign o_shifting = en_r;
    assign o_tdo      = tdo_r;
    assign o_data     = data_r;
    assign o_in_reset = (state_r == ST_RESET);

endmodule

`default_nettype wire

// file: dual_tap_test_port_tb.sv
// self-checking bench for the dual test access port
`timescale 1ns/1ns
`default_nettype none
module dual_tap_test_port_tb;
    import dual_tap_pkg::*;
    logic i_clk, i_resetn, i_test_resetn, i_test_clk, i_scan_mode_select;
    logic i_debug_mode_select, i_test_data_in, o_test_data_out, q, e;
    logic o_test_data_out_en, o_scan_in_reset, o_debug_in_reset;
    logic [DATA_W-1:0] o_scan_data, o_debug_data, got;
    int error_cnt = 0;
    int check_count = 0;
    dual_tap_test_port i_dual_tap_test_port (.i_clk, .i_resetn,
        .i_test_resetn, .i_test_clk, .i_scan_mode_select,
        .i_debug_mode_select, .i_test_data_in, .o_test_data_out,
        .o_test_data_out_en, .o_scan_data, .o_debug_data,
        .o_scan_in_reset, .o_debug_in_reset);
    tap_probe i_tap_probe (.o_test_clk(i_test_clk),
        .o_scan_sel(i_scan_mode_select), .o_debug_sel(i_debug_mode_select),
        .o_tdi(i_test_data_in), .o_test_resetn(i_test_resetn),
        .i_tdo(o_test_data_out), .i_tdo_en(o_test_data_out_en));
    // ****
    // helpers and scenarios
    // ****
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic check(input logic [31:0] got_v, input logic [31:0] exp);
        check_count++;
        if (got_v !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, got_v, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input logic sel, input logic t, input logic d);
        i_tap_probe.step(sel, t, d, q, e);
    endtask
    // walk the state machine, select bits taken lsb first
    task automatic path(input logic sel, input logic [3:0] s, input int n);
        for (int i = 0; i < n; i++) tick(sel, s[i], 1'b0);
    endtask
    // shift lsb first, then update and go back to idle
    task automatic shift(input logic sel, input int n, input logic [31:0] d);
        got = '0;
        for (int i = 0; i < n; i++) begin
            tick(sel, 1'(i == n - 1), d[i]);
            got[i] = q;
            check(32'(e), 32'h1);
        end
        tick(sel, 1'b1, 1'b0);
        check(32'(e), 32'h0);
        tick(sel, 1'b0, 1'b0);
    endtask
    // reset with the test clock standing still, then step to idle
    task automatic treset(input logic sel);
        i_tap_probe.set_reset(1'b0);
        #8;
        check(32'(o_test_data_out_en), 32'h0);
        check(32'({o_scan_in_reset, o_debug_in_reset}), 32'h3);
        i_tap_probe.set_reset(1'b1);
        #8;
        tick(sel, 1'b0, 1'b0);
    endtask
    task automatic t_reset();
        treset(1'b0);
        path(1'b0, 4'h1, 4);
        #40;
        check(32'(o_test_data_out_en), 32'h1);
        treset(1'b0);
        check(32'({o_scan_in_reset, o_debug_in_reset}), 32'h1);
        for (int i = 0; i < 5; i++) tick(1'b0, 1'b1, 1'b0);
        check(32'({o_scan_in_reset, o_debug_in_reset, e}), 32'h6);
        $display("reset test done");
    endtask
    task automatic t_idcode(input logic sel);
        treset(sel);
        path(sel, 4'h1, 3);
        shift(sel, 32, 32'h0);
        check(got, sel ? ID_DEBUG : ID_SCAN);
        check(32'(sel ? o_scan_in_reset : o_debug_in_reset), 32'h1);
        $display("identity test done");
    endtask
    task automatic t_data(input logic sel, input logic [31:0] w);
        treset(sel);
        path(sel, 4'h3, 4);
        shift(sel, 4, 32'(IR_DATA));
        check(got, 32'(IR_CAPTURE));
        path(sel, 4'h1, 3);
        shift(sel, 32, w);
        check(got, DATA_RST);
        check(sel ? o_debug_data : o_scan_data, w);
        path(sel, 4'h1, 3);
        shift(sel, 32, ~w);
        check(got, w);
        check(sel ? o_debug_data : o_scan_data, ~w);
        $display("data test done");
    endtask
    // bypass: one-bit path, so output lags input by one test clock
    task automatic t_bypass(input logic sel);
        treset(sel);
        path(sel, 4'h3, 4);
        shift(sel, 4, 32'(IR_BYPASS));
        check(got, 32'(IR_CAPTURE));
        path(sel, 4'h1, 3);
        shift(sel, 8, 32'h0000_006d);
        check(got, 32'h0000_00da);
        check(sel ? o_debug_data : o_scan_data, DATA_RST);
        $display("bypass test done");
    endtask
    initial begin
        i_resetn = 1'b0;
        repeat (10) @(posedge i_clk);
        #1;
        i_resetn = 1'b1;
        t_reset();
        t_idcode(1'b0);
        t_idcode(1'b1);
        t_data(1'b0, 32'ha5c3_0f17);
        t_data(1'b1, 32'h1234_5678);
        t_bypass(1'b0);
        t_bypass(1'b1);
        results();
    end
endmodule
`default_nettype wire

// file: tap_probe.sv
// model of the external tester on the test pins
`timescale 1ns/1ns
`default_nettype none
module tap_probe (
    output logic      o_test_clk,
    output logic      o_scan_sel,
    output logic      o_debug_sel,
    output logic      o_tdi,
    output logic      o_test_resetn,
    input  wire logic i_tdo,
    input  wire logic i_tdo_en
);
    logic last;
    // ****
    // tester pin behaviour
    // ****
    // test logic held in reset until a test starts
    initial begin
        o_test_clk = 1'b0;
        o_scan_sel = 1'b1;
        o_debug_sel = 1'b1;
        o_tdi = 1'b0;
        o_test_resetn = 1'b0;
        last = 1'b0;
    end
    task automatic set_reset(input logic v);
        o_test_resetn = v;
    endtask
    // one clock period; the clock stands low between calls
    // unused select held high
    task automatic step(input logic sel, input logic t, input logic d,
                        output logic q, output logic e);
        o_scan_sel = sel ? 1'b1 : t;
        o_debug_sel = sel ? t : 1'b1;
        o_tdi = d;
        #40;
        // a released pin reads back inverted, not as a stale level
        q = i_tdo_en ? i_tdo : ~last;
        last = q;
        e = i_tdo_en;
        o_test_clk = 1'b1;
        #40;
        o_test_clk = 1'b0;
    endtask
endmodule
`default_nettype wire
